// *** include/tqs_regs.svh ***
// register offsets, field positions, reset values and loop scaling of the torque select block
`ifndef TQS_REGS_SVH
`define TQS_REGS_SVH

`define TQS_ADDR_W 8
`define TQS_ADDR_CTRL 8'h00
`define TQS_ADDR_CURREQ 8'h04
`define TQS_ADDR_START 8'h08
`define TQS_ADDR_REGEN 8'h0c
`define TQS_ADDR_MOTOR 8'h10
`define TQS_ADDR_KP 8'h14
`define TQS_ADDR_KI 8'h18
`define TQS_ADDR_SPDREF 8'h1c
`define TQS_ADDR_CMD 8'h20
`define TQS_ADDR_RAW 8'h24
`define TQS_ADDR_FILT 8'h28

`define TQS_CTRL_SEL_BIT 0
`define TQS_CTRL_START_BIT 1
`define TQS_CTRL_EXP_LSB 4
`define TQS_CTRL_EXP_MSB 7

`define TQS_SEL_RST 1'h1
`define TQS_START_RST 1'h0
`define TQS_EXP_RST 4'h8
`define TQS_CEIL_RST 16'h0fff
`define TQS_ZERO16 16'h0000
`define TQS_KP_SHIFT 8
`define TQS_FRAC_BITS 8
`define TQS_SMOOTH_SHIFT 4

`define TQS_RESP_OKAY 2'h0
`define TQS_RESP_SLVERR 2'h2

`endif

// *** include/tqs_pkg.sv ***
// types shared by the torque select block and its speed feedback smoother
package tqs_pkg;

  // control loop sequence, one-hot
  typedef enum logic [3:0] {
    TQS_LP_IDLE = 4'h1,
    TQS_LP_PI = 4'h2,
    TQS_LP_SUM = 4'h4,
    TQS_LP_OUT = 4'h8
  } tqs_loop_t;

  // complete state of the top block
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic sel;
    logic startup;
    logic [3:0] exp;
    logic [15:0] curreq;
    logic [15:0] start_ceil;
    logic [15:0] regen_ceil;
    logic [15:0] motor_ceil;
    logic [15:0] kp;
    logic [15:0] ki;
    logic [15:0] spdref;
    logic [16:0] err;
    logic [23:0] integ;
    logic [15:0] pi_out;
    logic [15:0] cmd;
    logic cmd_valid;
    tqs_loop_t loop;
  } tqs_top_state_t;

  // complete state of the smoother
  typedef struct packed {
    logic [15:0] prev;
    logic [23:0] acc;
    logic [15:0] probe;
    logic out_valid;
  } tqs_smooth_state_t;

endpackage

// *** verilog/tqs_smoother.sv ***
// speed feedback smoother: input step limiter followed by a first-order low-pass
`timescale 1ns/1ps
`include "tqs_regs.svh"

module tqs_smoother #(
  parameter int SHIFT = `TQS_SMOOTH_SHIFT
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  input wire logic [15:0] in_data,
  input wire logic [3:0] exp,
  output logic [15:0] out_data,
  output logic out_valid,
  output logic [15:0] raw_probe
);
  import tqs_pkg::*;

  // the coefficient must stay inside the fraction bits of the accumulator
  generate
    if (SHIFT < 1 || SHIFT > `TQS_FRAC_BITS) begin : g_bad_shift
      $error("tqs_smoother: SHIFT out of range");
    end
  endgenerate

  tqs_smooth_state_t st, next_st;

  // step limit, then filter update
  always_comb begin
    logic signed [16:0] diff;
    logic signed [16:0] lim;
    logic signed [16:0] stepped;
    logic signed [24:0] delta;
    diff = 17'($signed(in_data)) - 17'($signed(st.prev));
    lim = 17'sh1 <<< exp;
    stepped = 17'h0;
    delta = 25'h0;
    next_st = st;
    next_st.out_valid = 1'b0;
    if (in_valid) begin
      next_st.probe = in_data;
      if (diff > lim) begin
        diff = lim; // [RULE8] [RULE9]
      end else if (diff < -lim) begin
        diff = -lim; // [RULE8] [RULE9]
      end
      stepped = 17'($signed(st.prev)) + diff;
      next_st.prev = stepped[15:0];
      delta = 25'($signed({stepped[15:0], 8'h00})) - 25'($signed(st.acc));
      next_st.acc = 24'($signed(st.acc) + 24'(delta >>> SHIFT));
      next_st.out_valid = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign out_data = st.acc[23:8];
  assign out_valid = st.out_valid;
  assign raw_probe = st.probe;
endmodule

// *** verilog/tqs_top.sv ***
// speed loop with torque/speed command selector ahead of the current ceiling clamp
// Operation
// RULE1 - select and request registers feed selector
// RULE2 - zero passes request, one passes regulator
// RULE3 - ceilings still clamp selected command
// RULE4 - software scales request like ceilings, 4095
// RULE5 - torque mode has no speed limiting
// RULE6 - zero gains hold regulator output zero
// RULE7 - mode change ramp is optional
// RULE8 - feedback step limited to two^exponent, 0-15
// RULE9 - step limit symmetric for both signs
`timescale 1ns/1ps
`include "tqs_regs.svh"

module tqs_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] speed_feedback,
  input wire logic speed_feedback_valid,
  output logic [15:0] current_command,
  output logic current_command_valid
);
  import tqs_pkg::*;

  tqs_top_state_t st, next_st;
  logic [15:0] filt_speed;
  logic filt_valid;
  logic [15:0] raw_speed_feedback_probe;

  // address decode, shared by read and write paths
  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      `TQS_ADDR_CTRL, `TQS_ADDR_CURREQ, `TQS_ADDR_START, `TQS_ADDR_REGEN,
      `TQS_ADDR_MOTOR, `TQS_ADDR_KP, `TQS_ADDR_KI, `TQS_ADDR_SPDREF,
      `TQS_ADDR_CMD, `TQS_ADDR_RAW, `TQS_ADDR_FILT: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
    merge16 = old;
    if (strb[0]) begin
      merge16[7:0] = d[7:0];
    end
    if (strb[1]) begin
      merge16[15:8] = d[15:8];
    end
  endfunction

  // saturate a wide signed value to 16 bits
  function automatic logic [15:0] sat16(input logic signed [35:0] v);
    if (v > 36'sh0_0000_7fff) begin
      sat16 = 16'h7fff;
    end else if (v < -36'sh0_0000_8000) begin
      sat16 = 16'h8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

  // saturate a wide signed value to 24 bits
  function automatic logic [23:0] sat24(input logic signed [35:0] v);
    if (v > 36'sh0_007f_ffff) begin
      sat24 = 24'h7fffff;
    end else if (v < -36'sh0_0080_0000) begin
      sat24 = 24'h800000;
    end else begin
      sat24 = v[23:0];
    end
  endfunction

  // register read mux
  function automatic logic [31:0] read_reg(input tqs_top_state_t s, input logic [7:0] a,
                                           input logic [15:0] raw, input logic [15:0] filt);
    read_reg = 32'h0;
    case (a)
      `TQS_ADDR_CTRL: begin
        read_reg[`TQS_CTRL_SEL_BIT] = s.sel;
        read_reg[`TQS_CTRL_START_BIT] = s.startup;
        read_reg[`TQS_CTRL_EXP_MSB:`TQS_CTRL_EXP_LSB] = s.exp;
      end
      `TQS_ADDR_CURREQ: read_reg[15:0] = s.curreq;
      `TQS_ADDR_START: read_reg[15:0] = s.start_ceil;
      `TQS_ADDR_REGEN: read_reg[15:0] = s.regen_ceil;
      `TQS_ADDR_MOTOR: read_reg[15:0] = s.motor_ceil;
      `TQS_ADDR_KP: read_reg[15:0] = s.kp;
      `TQS_ADDR_KI: read_reg[15:0] = s.ki;
      `TQS_ADDR_SPDREF: read_reg[15:0] = s.spdref;
      `TQS_ADDR_CMD: read_reg[15:0] = s.cmd;
      `TQS_ADDR_RAW: read_reg[15:0] = raw;
      `TQS_ADDR_FILT: read_reg[15:0] = filt;
      default: read_reg = 32'h0;
    endcase
  endfunction

  // speed feedback smoother with step limiter
  tqs_smoother #(
    .SHIFT(`TQS_SMOOTH_SHIFT)
  ) u_speed_feedback_smoother (
    .clk(clk),
    .reset(reset),
    .in_valid(speed_feedback_valid),
    .in_data(speed_feedback),
    .exp(st.exp), // [RULE8]
    .out_data(filt_speed),
    .out_valid(filt_valid),
    .raw_probe(raw_speed_feedback_probe)
  );

  // bus slave and control loop next state
  always_comb begin
    logic signed [33:0] prod_i;
    logic signed [33:0] prod_p;
    logic signed [35:0] wide;
    logic signed [15:0] sel_cmd;
    logic signed [15:0] hi;
    logic signed [16:0] lo;
    logic gains_zero;
    prod_i = 34'h0;
    prod_p = 34'h0;
    wide = 36'h0;
    sel_cmd = 16'h0;
    hi = 16'h0;
    lo = 17'h0;
    gains_zero = (st.kp == 16'h0) && (st.ki == 16'h0);
    next_st = st;
    next_st.cmd_valid = 1'b0;

    // write address and data, taken in either order
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
      next_st.awready = 1'b0;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
      next_st.wready = 1'b0;
    end

    // perform the write once both halves are held
    if (st.aw_held && st.w_held && !st.bvalid) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = is_mapped(st.aw_addr) ? `TQS_RESP_OKAY : `TQS_RESP_SLVERR;
      case (st.aw_addr)
        `TQS_ADDR_CTRL: begin
          if (st.w_strb[0]) begin
            next_st.sel = st.w_data[`TQS_CTRL_SEL_BIT]; // [RULE1]
            next_st.startup = st.w_data[`TQS_CTRL_START_BIT];
            next_st.exp = st.w_data[`TQS_CTRL_EXP_MSB:`TQS_CTRL_EXP_LSB]; // [RULE8]
          end
        end
        `TQS_ADDR_CURREQ: next_st.curreq = merge16(st.curreq, st.w_data, st.w_strb); // [RULE1]
        `TQS_ADDR_START: next_st.start_ceil = merge16(st.start_ceil, st.w_data, st.w_strb);
        `TQS_ADDR_REGEN: next_st.regen_ceil = merge16(st.regen_ceil, st.w_data, st.w_strb);
        `TQS_ADDR_MOTOR: next_st.motor_ceil = merge16(st.motor_ceil, st.w_data, st.w_strb);
        `TQS_ADDR_KP: next_st.kp = merge16(st.kp, st.w_data, st.w_strb);
        `TQS_ADDR_KI: next_st.ki = merge16(st.ki, st.w_data, st.w_strb);
        `TQS_ADDR_SPDREF: next_st.spdref = merge16(st.spdref, st.w_data, st.w_strb);
        default: next_st.bresp = next_st.bresp;
      endcase
    end

    // write response, then reopen both channels
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
    end

    // read address and response
    if (s_axi_arvalid && st.arready) begin
      next_st.arready = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rdata = read_reg(st, s_axi_araddr, raw_speed_feedback_probe, filt_speed);
      next_st.rresp = is_mapped(s_axi_araddr) ? `TQS_RESP_OKAY : `TQS_RESP_SLVERR;
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end

    // speed regulator, selector and ceiling clamp
    case (st.loop)
      TQS_LP_IDLE: begin
        if (filt_valid) begin
          next_st.err = 17'($signed(st.spdref)) - 17'($signed(filt_speed));
          next_st.loop = TQS_LP_PI;
        end
      end
      TQS_LP_PI: begin
        prod_i = $signed({1'b0, st.ki}) * $signed(st.err);
        wide = 36'($signed(st.integ)) + 36'(prod_i >>> `TQS_KP_SHIFT);
        next_st.integ = gains_zero ? 24'h0 : sat24(wide); // [RULE6]
        next_st.loop = TQS_LP_SUM;
      end
      TQS_LP_SUM: begin
        prod_p = $signed({1'b0, st.kp}) * $signed(st.err);
        wide = 36'(prod_p >>> `TQS_KP_SHIFT) + 36'($signed(st.integ) >>> `TQS_FRAC_BITS);
        next_st.pi_out = gains_zero ? 16'h0 : sat16(wide); // [RULE6]
        next_st.loop = TQS_LP_OUT;
      end
      TQS_LP_OUT: begin
        // no speed ceiling in torque mode: only current ceilings apply
        sel_cmd = st.sel ? $signed(st.pi_out) : $signed(st.curreq); // [RULE2] [RULE5]
        hi = st.startup ? $signed(st.start_ceil) : $signed(st.motor_ceil);
        lo = -17'($signed(st.regen_ceil));
        if (17'(sel_cmd) > 17'(hi)) begin
          next_st.cmd = hi; // [RULE3]
        end else if (17'(sel_cmd) < lo) begin
          next_st.cmd = lo[15:0]; // [RULE3]
        end else begin
          next_st.cmd = sel_cmd;
        end
        next_st.cmd_valid = 1'b1;
        next_st.loop = TQS_LP_IDLE;
      end
      default: next_st.loop = TQS_LP_IDLE;
    endcase
  end

  // state register with reset values
  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
      st.sel <= `TQS_SEL_RST;
      st.startup <= `TQS_START_RST;
      st.exp <= `TQS_EXP_RST;
      st.curreq <= `TQS_ZERO16;
      st.start_ceil <= `TQS_CEIL_RST;
      st.regen_ceil <= `TQS_CEIL_RST;
      st.motor_ceil <= `TQS_CEIL_RST;
      st.loop <= TQS_LP_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state flops
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign current_command = st.cmd;
  assign current_command_valid = st.cmd_valid;
endmodule

// *** dv/tqs_top_asserts.sv ***
// port-level checks on the torque select block, bound into tqs_top
`timescale 1ns/1ps
`include "tqs_regs.svh"

module tqs_top_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic speed_feedback_valid,
  input wire logic [15:0] current_command,
  input wire logic current_command_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // register bus timing and channel blocking
  a_write_resp: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response not two cycles after address and data");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel open while response pending");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open while data pending");
  a_slverr_zero: assert property (
    s_axi_rvalid && s_axi_rresp == `TQS_RESP_SLVERR |-> s_axi_rdata == 32'h00000000)
    else $error("error read returned nonzero data");

  // speed loop result timing and holding
  // sample edge, smoother, error, integrator, sum, clamp: pulse seen five edges later
  a_cmd_latency: assert property (
    current_command_valid |-> $past(speed_feedback_valid, 5))
    else $error("command not five cycles after sample");
  a_cmd_hold: assert property (
    !current_command_valid && !$past(reset) |-> $stable(current_command))
    else $error("command changed without valid");
  a_valid_pulse: assert property (current_command_valid |=> !current_command_valid)
    else $error("command valid longer than one cycle");
endmodule

bind tqs_top tqs_top_asserts i_tqs_top_asserts (.clk, .reset, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rdata, .s_axi_rresp, .speed_feedback_valid, .current_command, .current_command_valid);

// *** dv/tb.sv ***
// self-checking bench for the torque select block over its register bus and speed loop
`timescale 1ns/1ps
`include "tqs_regs.svh"

module tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, speed_feedback_valid = 1'b0;
  logic [15:0] speed_feedback = 16'h0000;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic current_command_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic [15:0] current_command, cmd;
  int n_errors = 0, n_compared = 0, prev = 0, acc = 0, d, lim;
  // torque mode cases: request, startup bit, clamped result
  logic [15:0] tq_req [4] = '{16'h0100, 16'h2000, 16'hf000, 16'h2000};
  logic tq_st [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
  logic [15:0] tq_exp [4] = '{16'h0100, 16'h0fff, 16'hf001, 16'h0800};
  // step limiter cases: exponent and raw sample
  logic [3:0] f_exp [4] = '{4'h0, 4'hf, 4'h4, 4'h8};
  logic [15:0] f_s [4] = '{16'h0100, 16'h4000, 16'hc000, 16'h8000};

  // 200 MHz clock
  always #2.5 clk = ~clk;

  tqs_top i_tqs_top (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .speed_feedback, .speed_feedback_valid, .current_command,
    .current_command_valid);

  // verdict and end of run
  task automatic tally_and_finish();
    if (n_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one comparison, mismatch reported at once
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // bound on every wait loop
  task automatic guard(inout int n);
    n++;
    if (n > 100) begin
      n_errors++;
      tally_and_finish();
    end
  endtask

  // bus write: address and data offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    logic ta, tw, b;
    n = 0;
    b = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b) begin
      @(negedge clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      guard(n);
    end
    s_axi_bready <= 1'b0;
    chk({30'h0, rsp}, {30'h0, er});
  endtask

  // bus read: data and response taken at the edge where rvalid is seen
  task automatic axr(input logic [7:0] a, output logic [31:0] v);
    int n;
    logic ta, r;
    n = 0;
    r = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r) begin
      @(negedge clk);
      ta = s_axi_arvalid & s_axi_arready;
      r = s_axi_rvalid;
      v = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
      guard(n);
    end
    s_axi_rready <= 1'b0;
  endtask

  // one speed sample, then wait for the command it produces
  task automatic fb(input logic [15:0] s);
    int n;
    logic v;
    n = 0;
    v = 1'b0;
    @(posedge clk);
    speed_feedback <= s;
    speed_feedback_valid <= 1'b1;
    @(posedge clk);
    speed_feedback_valid <= 1'b0;
    while (!v) begin
      @(negedge clk);
      v = current_command_valid;
      cmd = current_command;
      guard(n);
    end
  endtask

  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    axr(`TQS_ADDR_CTRL, rd);
    chk(rd, 32'h00000081);
    axr(`TQS_ADDR_MOTOR, rd);
    chk(rd, 32'h00000fff);
    chk({30'h0, rsp}, {30'h0, `TQS_RESP_OKAY});
    axr(8'h3c, rd);
    chk(rd, 32'h00000000);
    chk({30'h0, rsp}, {30'h0, `TQS_RESP_SLVERR});
    axw(8'h3c, 32'h00000001, `TQS_RESP_SLVERR);
    axw(`TQS_ADDR_START, 32'h00000800, `TQS_RESP_OKAY);
    // torque mode passes the request through the ceilings
    foreach (tq_req[i]) begin
      axw(`TQS_ADDR_CURREQ, {16'h0, tq_req[i]}, `TQS_RESP_OKAY);
      axw(`TQS_ADDR_CTRL, {24'h0, 4'h8, 2'h0, tq_st[i], 1'b0}, `TQS_RESP_OKAY);
      fb(16'h0000);
      chk({16'h0, cmd}, {16'h0, tq_exp[i]});
      axr(`TQS_ADDR_CMD, rd);
      chk(rd, {16'h0, tq_exp[i]});
    end
    axw(`TQS_ADDR_CMD, 32'h00001234, `TQS_RESP_OKAY);
    axr(`TQS_ADDR_CMD, rd);
    chk(rd, 32'h00000800);
    // speed mode: zero gains give zero, unit gain passes the error
    axw(`TQS_ADDR_SPDREF, 32'h00000200, `TQS_RESP_OKAY);
    // mode change straight from torque to speed, no ramp stage in between
    axw(`TQS_ADDR_CTRL, 32'h00000081, `TQS_RESP_OKAY);
    fb(16'h0000);
    chk({16'h0, cmd}, 32'h00000000);
    axw(`TQS_ADDR_KP, 32'h00000100, `TQS_RESP_OKAY);
    fb(16'h0000);
    chk({16'h0, cmd}, 32'h00000200);
    // step limiter and smoother against a reference model, in torque mode
    axw(`TQS_ADDR_CURREQ, 32'h00000100, `TQS_RESP_OKAY);
    foreach (f_exp[i]) begin
      axw(`TQS_ADDR_CTRL, {24'h0, f_exp[i], 4'h0}, `TQS_RESP_OKAY);
      fb(f_s[i]);
      lim = 1 << f_exp[i];
      d = int'($signed(f_s[i])) - prev;
      if (d > lim) d = lim;
      if (d < -lim) d = -lim;
      prev = prev + d;
      acc = acc + (((prev <<< `TQS_FRAC_BITS) - acc) >>> `TQS_SMOOTH_SHIFT);
      chk({16'h0, cmd}, 32'h00000100);
      axr(`TQS_ADDR_FILT, rd);
      chk(rd, {16'h0, 16'(acc >>> `TQS_FRAC_BITS)});
    end
    // probe shows the last sample before the step limit
    axr(`TQS_ADDR_RAW, rd);
    chk(rd, {16'h0, f_s[3]});
    // lowered regenerative ceiling bounds a negative request
    axw(`TQS_ADDR_REGEN, 32'h00000100, `TQS_RESP_OKAY);
    axw(`TQS_ADDR_CURREQ, 32'h0000f000, `TQS_RESP_OKAY);
    fb(f_s[3]);
    chk({16'h0, cmd}, 32'h0000ff00);
    tally_and_finish();
  end
endmodule
